// >>> hdl/scr_top.sv
// Serializer configuration register bank with its SMBus slave
// Notes on behaviour
// R1 - Bits 7:1 of offset 0x00 are the address this device answers to.
// R2 - Host writes zero to bit 0 of the address register; it is reserved.
// R3 - Address field is writable and a new value takes effect at once.
// R4 - Writing one to bit 0 of offset 0x01 starts a soft reset.
// R5 - Soft reset restores power-up state except the address register.
// R6 - The reset trigger clears itself afterwards, reading back zero.
// R7 - Bit 4 of offset 0x01 powers down output buffer; default zero.
// R8 - Pin 0 source: 0 output register, 3 clock loss, 4 detect, 6 POR.
// R9 - Pin 0 pull: 00 none, 01 pulldown, 10 pullup; default pulldown.
// R10 - Bit 1 of pin 0 configuration enables its input buffer; default off.
// R11 - Bit 0 of pin 0 configuration enables its driver; default on.
// R12 - Software keeps pin 0 either input or output, not both.
// R13 - Reserved bits read as zero and ignore writes.
`timescale 1ns/10ps
module scr_top
  import scr_pkg::*;
#(
  // Arbitrary value
  parameter logic [6:0] DEFAULT_BUS_ADDR = 7'h2a
)
(
  // Clock, reset and enable
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // SMBus pins, open drain
  input  wire logic smb_scl_in,
  input  wire logic smb_sda_in,
  input  wire logic smb_select,
  output logic      smb_sda_out,
  output logic      smb_sda_oe,
  // Link clock from the host
  input  wire logic host_ddr_clock,
  // Pin 0 pad and its sources
  input  wire logic pin0_gpout_level,
  input  wire logic pin0_pad_in,
  output logic      pin0_pad_out,
  output logic      pin0_output_drive_on,
  output logic      pin0_pull_up,
  output logic      pin0_pull_down,
  output logic      pin0_in_buf_en,
  output logic      pin0_in_level,
  // Serial output buffer control
  output logic      out_buffer_power_down
);

  scr_mon_if mon ();

  // Synchronised pins
  logic scl_meta;
  logic scl_sync;
  logic scl_prev;
  logic sda_meta;
  logic sda_sync;
  logic sda_prev;
  logic sel_meta;
  logic sel_sync;
  logic pin_meta;
  logic pin_sync;

  // Bus engine
  scr_bus_state_e state;
  logic [3:0]     bit_cnt;
  logic [7:0]     shift;
  logic [7:0]     reg_ptr;
  logic           reading;
  logic           have_offset;
  logic           master_nack;
  logic [7:0]     rd_byte;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_cond;
  logic           stop_cond;
  logic           wr_strobe;

  // Register fields and the power-on reset counter
  logic [6:0] bus_address_field;
  logic       soft_reset_trigger;
  logic       power_down;
  logic [3:0] pin0_mode;
  logic [1:0] pin0_pull;
  logic       pin0_inbuf;
  logic       pin0_drive;
  logic [4:0] por_cnt;

  scr_clock_monitor u_monitor (
    .clk            (clk),
    .rst            (rst),
    .host_ddr_clock (host_ddr_clock),
    .mon            (mon.monitor)
  );

  assign mon.ce    = ce;
  assign mon.clear = soft_reset_trigger; // [R5]

  // Read view of a register; unmapped offsets read zero
  function automatic logic [7:0] reg_read(input logic [7:0] ofs);
    logic [7:0] v;
    v = 8'h00;
    case (ofs)
      OFS_BUS_ADDR: begin
        v[7:BUS_ADDR_LSB] = bus_address_field; // [R13]
      end
      OFS_RESET_CTRL: begin
        v[POWER_DOWN_BIT] = power_down; // [R7]
        v[TRIGGER_BIT]    = soft_reset_trigger; // [R6]
      end
      OFS_PIN0_CFG: begin
        v[PIN0_MODE_LSB +: 4] = pin0_mode;
        v[PIN0_PULL_LSB +: 2] = pin0_pull;
        v[PIN0_INBUF_BIT]     = pin0_inbuf;
        v[PIN0_DRIVE_BIT]     = pin0_drive;
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction

  assign rd_byte = reg_read(reg_ptr);

  // Two flops on the SCL, SDA, select and pad inputs before any logic looks at them
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
      sel_meta <= 1'b0;
      sel_sync <= 1'b0;
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else if (ce) begin
      scl_meta <= smb_scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= smb_sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
      sel_meta <= smb_select;
      sel_sync <= sel_meta;
      pin_meta <= pin0_pad_in;
      pin_sync <= pin_meta;
    end
  end

  assign scl_rise   = scl_sync & ~scl_prev;
  assign scl_fall   = ~scl_sync & scl_prev;
  assign start_cond = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_cond  = scl_sync & scl_prev & ~sda_prev & sda_sync;
  assign wr_strobe  = ce && sel_sync && state == ST_WR && scl_fall &&
                      bit_cnt == BYTE_BITS && have_offset;

  // SMBus slave; the open-drain data line is only ever pulled low
  always_ff @(posedge clk) begin
    if (rst) begin
      state       <= ST_IDLE;
      bit_cnt     <= 4'h0;
      shift       <= 8'h00;
      reg_ptr     <= 8'h00;
      reading     <= 1'b0;
      have_offset <= 1'b0;
      master_nack <= 1'b0;
      smb_sda_oe  <= 1'b0;
    end else if (ce) begin
      if (stop_cond || !sel_sync) begin
        state      <= ST_IDLE;
        smb_sda_oe <= 1'b0;
      end else if (start_cond) begin
        state       <= ST_ADDR;
        bit_cnt     <= 4'h0;
        have_offset <= 1'b0;
        smb_sda_oe  <= 1'b0;
      end else begin
        case (state)
          ST_ADDR: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_sync};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == BYTE_BITS) begin
              if (shift[7:1] == bus_address_field) begin // [R1] [R3]
                state      <= ST_ADDR_ACK;
                smb_sda_oe <= 1'b1;
                reading    <= shift[0];
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (reading) begin
                state      <= ST_RD;
                shift      <= rd_byte;
                smb_sda_oe <= ~rd_byte[7];
              end else begin
                state      <= ST_WR;
                smb_sda_oe <= 1'b0;
              end
            end
          end
          ST_WR: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_sync};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == BYTE_BITS) begin
              state      <= ST_WR_ACK;
              smb_sda_oe <= 1'b1;
              if (!have_offset) begin
                reg_ptr     <= shift;
                have_offset <= 1'b1;
              end else begin
                reg_ptr <= reg_ptr + 8'h01;
              end
            end
          end
          ST_WR_ACK: begin
            if (scl_fall) begin
              state      <= ST_WR;
              bit_cnt    <= 4'h0;
              smb_sda_oe <= 1'b0;
            end
          end
          ST_RD: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == BYTE_BITS) begin
              state      <= ST_RD_ACK;
              smb_sda_oe <= 1'b0;
              reg_ptr    <= reg_ptr + 8'h01;
            end else if (scl_fall && bit_cnt != 4'h0) begin
              shift      <= {shift[6:0], 1'b0};
              smb_sda_oe <= ~shift[6];
            end
          end
          ST_RD_ACK: begin
            if (scl_rise) begin
              master_nack <= sda_sync;
            end else if (scl_fall) begin
              if (master_nack) begin
                state <= ST_IDLE;
              end else begin
                state      <= ST_RD;
                bit_cnt    <= 4'h0;
                shift      <= rd_byte;
                smb_sda_oe <= ~rd_byte[7];
              end
            end
          end
          default: begin
            state      <= ST_IDLE;
            smb_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Pulling low only, so the driven level never changes
  always_ff @(posedge clk) begin
    smb_sda_out <= 1'b0;
  end

  // Address register survives a soft reset on purpose
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_address_field <= DEFAULT_BUS_ADDR;
    end else if (ce && wr_strobe && reg_ptr == OFS_BUS_ADDR) begin
      bus_address_field <= shift[7:BUS_ADDR_LSB]; // [R3] [R5] [R13]
    end
  end

  // Trigger lives one cycle, so a later read returns zero
  always_ff @(posedge clk) begin
    if (rst) begin
      soft_reset_trigger <= 1'b0;
    end else if (ce) begin
      if (soft_reset_trigger) begin
        soft_reset_trigger <= 1'b0; // [R6]
      end else if (wr_strobe && reg_ptr == OFS_RESET_CTRL) begin
        soft_reset_trigger <= shift[TRIGGER_BIT]; // [R4]
      end
    end
  end

  // Control fields; reserved bits are not stored
  always_ff @(posedge clk) begin
    if (rst) begin
      power_down <= POWER_DOWN_RESET;
      pin0_mode  <= PIN0_MODE_RESET;
      pin0_pull  <= PIN0_PULL_RESET;
      pin0_inbuf <= PIN0_INBUF_RESET;
      pin0_drive <= PIN0_DRIVE_RESET;
    end else if (ce) begin
      if (soft_reset_trigger) begin
        power_down <= POWER_DOWN_RESET; // [R5]
        pin0_mode  <= PIN0_MODE_RESET;
        pin0_pull  <= PIN0_PULL_RESET;
        pin0_inbuf <= PIN0_INBUF_RESET;
        pin0_drive <= PIN0_DRIVE_RESET;
      end else if (wr_strobe && reg_ptr == OFS_RESET_CTRL) begin
        power_down <= shift[POWER_DOWN_BIT]; // [R7] [R13]
      end else if (wr_strobe && reg_ptr == OFS_PIN0_CFG) begin
        pin0_mode  <= shift[PIN0_MODE_LSB +: 4]; // [R8]
        pin0_pull  <= shift[PIN0_PULL_LSB +: 2]; // [R9]
        pin0_inbuf <= shift[PIN0_INBUF_BIT]; // [R10]
        pin0_drive <= shift[PIN0_DRIVE_BIT]; // [R11]
      end
    end
  end

  // Power-on reset indication, restarted by a soft reset
  always_ff @(posedge clk) begin
    if (rst) begin
      por_cnt <= POR_STRETCH_CYC;
    end else if (ce) begin
      if (soft_reset_trigger) begin
        por_cnt <= POR_STRETCH_CYC; // [R5]
      end else if (por_cnt != 5'h00) begin
        por_cnt <= por_cnt - 5'h01;
      end
    end
  end

  // Pin 0 source mux; reserved codes drive low
  always_ff @(posedge clk) begin
    if (rst) begin
      pin0_pad_out <= 1'b0;
    end else if (ce) begin
      case (pin0_mode) // [R8]
        PIN0_MODE_GPOUT:  pin0_pad_out <= pin0_gpout_level;
        PIN0_MODE_LOSS:   pin0_pad_out <= mon.lost;
        PIN0_MODE_DETECT: pin0_pad_out <= mon.seen;
        PIN0_MODE_POR:    pin0_pad_out <= por_cnt != 5'h00;
        default:          pin0_pad_out <= 1'b0;
      endcase
    end
  end

  // Pad controls; reserved pull code leaves both resistors off.
  // Both buffers may be on at once: keeping them apart is up to software.
  always_ff @(posedge clk) begin
    if (rst) begin
      pin0_output_drive_on  <= PIN0_DRIVE_RESET;
      pin0_pull_up          <= 1'b0;
      pin0_pull_down        <= 1'b1;
      pin0_in_buf_en        <= PIN0_INBUF_RESET;
      pin0_in_level         <= 1'b0;
      out_buffer_power_down <= POWER_DOWN_RESET;
    end else if (ce) begin
      pin0_output_drive_on  <= pin0_drive; // [R11]
      pin0_pull_up          <= pin0_pull == PULL_UP; // [R9]
      pin0_pull_down        <= pin0_pull == PULL_DOWN; // [R9]
      pin0_in_buf_en        <= pin0_inbuf; // [R10]
      pin0_in_level         <= pin0_inbuf & pin_sync; // [R10]
      out_buffer_power_down <= power_down; // [R7]
    end
  end

endmodule

// >>> hdl/scr_pkg.sv
// Constants and types shared by the serializer configuration register bank
package scr_pkg;

  // Register offsets
  localparam logic [7:0] OFS_BUS_ADDR   = 8'h00;
  localparam logic [7:0] OFS_RESET_CTRL = 8'h01;
  localparam logic [7:0] OFS_PIN0_CFG   = 8'h02;

  // Field positions
  localparam int BUS_ADDR_LSB    = 1;
  localparam int TRIGGER_BIT     = 0;
  localparam int POWER_DOWN_BIT  = 4;
  localparam int PIN0_MODE_LSB   = 4;
  localparam int PIN0_PULL_LSB   = 2;
  localparam int PIN0_INBUF_BIT  = 1;
  localparam int PIN0_DRIVE_BIT  = 0;

  // Pin 0 source selection codes
  localparam logic [3:0] PIN0_MODE_GPOUT  = 4'h0;
  localparam logic [3:0] PIN0_MODE_LOSS   = 4'h3;
  localparam logic [3:0] PIN0_MODE_DETECT = 4'h4;
  localparam logic [3:0] PIN0_MODE_POR    = 4'h6;

  // Pin 0 pull resistor codes
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP   = 2'h2;

  // Values after reset
  localparam logic       POWER_DOWN_RESET = 1'b0;
  localparam logic [3:0] PIN0_MODE_RESET  = PIN0_MODE_GPOUT;
  localparam logic [1:0] PIN0_PULL_RESET  = PULL_DOWN;
  localparam logic       PIN0_INBUF_RESET = 1'b0;
  localparam logic       PIN0_DRIVE_RESET = 1'b1;

  // Serial byte framing
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Timing
  localparam int CLK_PERIOD_PS    = 4000;
  localparam int HOST_CLK_LOSS_NS = 1000;
  localparam int POR_STRETCH_NS   = 64;
  localparam logic [8:0] HOST_CLK_LOSS_CYC =
    9'((HOST_CLK_LOSS_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [4:0] POR_STRETCH_CYC =
    5'((POR_STRETCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // Reset stretch toward the link side, long enough for three link edges
  localparam logic [4:0] LINK_RST_CYC = 5'h1f;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR,
    ST_WR_ACK,
    ST_RD,
    ST_RD_ACK
  } scr_bus_state_e;

endpackage

// >>> hdl/scr_mon_if.sv
// Status and control between the register bank and the host clock monitor
`timescale 1ns/10ps
interface scr_mon_if;
  logic clear;
  logic ce;
  logic seen;
  logic lost;

  modport monitor (
    input  clear,
    input  ce,
    output seen,
    output lost
  );

  modport bank (
    output clear,
    output ce,
    input  seen,
    input  lost
  );
endinterface

// >>> hdl/scr_clock_monitor.sv
// Host DDR clock activity monitor: detect and loss flags in the clk domain
`timescale 1ns/10ps
module scr_clock_monitor
  import scr_pkg::*;
(
  // System clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Link clock from the host
  input  wire logic host_ddr_clock,
  // Status toward the register bank
  scr_mon_if.monitor mon
);

  logic [4:0] link_hold;
  logic       link_rst_req;
  logic       link_rst_meta;
  logic       link_rst;
  logic       link_toggle;
  logic       tog_meta;
  logic       tog_sync;
  logic       tog_prev;
  logic [8:0] idle_cnt;

  // The link clock is slower than clk, so a short reset is stretched
  // until the link side has seen enough of its own edges
  always_ff @(posedge clk) begin
    if (rst) begin
      link_hold    <= LINK_RST_CYC;
      link_rst_req <= 1'b1;
    end else if (mon.ce) begin
      if (link_hold != 5'h00) begin
        link_hold <= link_hold - 5'h01;
      end
      link_rst_req <= link_hold != 5'h00;
    end
  end

  // Reset reaches the link domain through two flops
  always_ff @(posedge host_ddr_clock) begin
    link_rst_meta <= link_rst_req;
    link_rst      <= link_rst_meta;
  end

  // One toggle per rising link edge; the clk side only ever sees a level
  always_ff @(posedge host_ddr_clock) begin
    if (link_rst) begin
      link_toggle <= 1'b0;
    end else begin
      link_toggle <= ~link_toggle;
    end
  end

  always_ff @(posedge clk) begin
    // Held until the link toggle has left its unknown power-up value
    if (rst || link_rst_req) begin
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_prev <= 1'b0;
    end else if (mon.ce) begin
      tog_meta <= link_toggle;
      tog_sync <= tog_meta;
      tog_prev <= tog_sync;
    end
  end

  // A stopped clock is declared lost once no edge arrives for the window
  always_ff @(posedge clk) begin
    if (rst || (mon.clear && mon.ce)) begin
      idle_cnt <= 9'h000;
      mon.seen <= 1'b0;
      mon.lost <= 1'b0;
    end else if (mon.ce) begin
      if (tog_sync != tog_prev) begin
        idle_cnt <= 9'h000;
        mon.seen <= 1'b1;
        mon.lost <= 1'b0;
      end else if (idle_cnt != HOST_CLK_LOSS_CYC) begin
        idle_cnt <= idle_cnt + 9'h001;
      end else begin
        mon.seen <= 1'b0;
        mon.lost <= 1'b1;
      end
    end
  end

endmodule

// >>> test/scr_top_assertions.sv
// Port-level concurrent checks for the configuration register bank
`timescale 1ns/10ps
module scr_top_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // SMBus pins
  input wire logic smb_scl_in,
  input wire logic smb_select,
  input wire logic smb_sda_out,
  input wire logic smb_sda_oe,
  // Pin 0 and output buffer
  input wire logic pin0_output_drive_on,
  input wire logic pin0_pull_up,
  input wire logic pin0_pull_down,
  input wire logic pin0_in_buf_en,
  input wire logic pin0_in_level,
  input wire logic out_buffer_power_down
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  logic [3:0] cfg;
  assign cfg = {pin0_pull_up, pin0_pull_down, pin0_in_buf_en,
                pin0_output_drive_on};

  a_reset_values: assert property (
    $fell(rst) |-> cfg == 4'h5 && !out_buffer_power_down && !smb_sda_oe)
    else $error("output off its reset value");
  a_pull_exclusive: assert property (
    !(pin0_pull_up && pin0_pull_down))
    else $error("both pulls enabled");
  a_in_gated: assert property (
    pin0_in_level |-> pin0_in_buf_en)
    else $error("input level passed with buffer off");
  // Writes land a few cycles after an SCL fall, never with SCL high
  a_cfg_on_write: assert property (
    $changed(cfg) |-> $past(!smb_scl_in, 4))
    else $error("pin config changed outside a write");
  a_pd_on_write: assert property (
    $changed(out_buffer_power_down) |-> $past(!smb_scl_in, 4))
    else $error("power down changed outside a write");
  a_oe_on_fall: assert property (
    smb_select && $changed(smb_sda_oe) |-> $past(!smb_scl_in, 2))
    else $error("SDA moved while SCL high");
  a_oe_holds: assert property (
    disable iff (rst || !smb_select)
    $rose(smb_sda_oe) |-> smb_sda_oe [*5])
    else $error("SDA drive too short");
  a_sda_out_low: assert property (
    smb_sda_out == 1'b0)
    else $error("open drain data not low");

  cover property ($rose(smb_sda_oe));
  cover property ($rose(out_buffer_power_down));
  cover property ($fell(pin0_output_drive_on));
endmodule

bind scr_top scr_top_assertions scr_top_assertions_i (
  .clk(clk), .rst(rst), .smb_scl_in(smb_scl_in),
  .smb_select(smb_select), .smb_sda_out(smb_sda_out),
  .smb_sda_oe(smb_sda_oe), .pin0_output_drive_on(pin0_output_drive_on),
  .pin0_pull_up(pin0_pull_up), .pin0_pull_down(pin0_pull_down),
  .pin0_in_buf_en(pin0_in_buf_en), .pin0_in_level(pin0_in_level),
  .out_buffer_power_down(out_buffer_power_down));

// >>> test/scr_host_model.sv
// Behavioural SMBus master and link clock source on the host side
`timescale 1ns/10ps
module scr_host_model (
  // Pacing clock, resolved data wire and link clock enable
  input  wire logic clk,
  input  wire logic sda_line,
  input  wire logic link_run,
  // Pins toward the device
  output logic      scl,
  output logic      sda_pull_low,
  output logic      host_ddr_clock
);
  // Link clock halts only when a test wants the loss flag
  initial begin
    scl = 1'b1;
    sda_pull_low = 1'b0;
    host_ddr_clock = 1'b0;
    #3.3;
    forever #15 if (link_run) host_ddr_clock = ~host_ddr_clock;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // SCL phases of 10 cycles, twice the least the device needs
  task automatic put_bit(input logic b);
    sda_pull_low = ~b;
    hold(10);
    scl = 1'b1;
    hold(10);
    scl = 1'b0;
  endtask
  task automatic get_bit(output logic b);
    sda_pull_low = 1'b0;
    hold(10);
    scl = 1'b1;
    hold(5);
    b = sda_line;
    hold(5);
    scl = 1'b0;
  endtask
  task automatic start();
    sda_pull_low = 1'b0;
    hold(10);
    scl = 1'b1;
    hold(10);
    sda_pull_low = 1'b1;
    hold(10);
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_pull_low = 1'b1;
    hold(10);
    scl = 1'b1;
    hold(10);
    sda_pull_low = 1'b0;
    hold(10);
  endtask
  task automatic send(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(b);
    ack = ~b;
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] o,
                           input logic [7:0] v, output logic ok);
    logic k0, k1, k2;
    start();
    send({a, 1'b0}, k0);
    send(o, k1);
    send(v, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask
  task automatic read_reg(input logic [6:0] a, input logic [7:0] o,
                          output logic [7:0] v, output logic ok);
    logic k0, k1, k2;
    start();
    send({a, 1'b0}, k0);
    send(o, k1);
    start();
    send({a, 1'b1}, k2);
    for (int i = 7; i >= 0; i--) get_bit(v[i]);
    put_bit(1'b1);
    stop();
    ok = k0 & k1 & k2;
  endtask
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/10ps
module tb_top;
  import scr_pkg::*;
  // Arbitrary addresses
  localparam logic [6:0] ADDR0 = 7'h2a;
  localparam logic [6:0] ADDR1 = 7'h33;
  typedef struct packed {
    logic [7:0] off;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [5:0] pins;
  } scr_row_s;

  logic       clk, rst, gpout, pad_in, link_run, scl, sda_pull_low, ce;
  logic       sda_line, smb_sda_out, smb_sda_oe, pad_out, ok, host_clk;
  logic       drive_on, pull_up, pull_down, in_buf_en, in_level, pd;
  logic [7:0] d, pins;
  int         fail_count, total_checks;
  scr_row_s   rows [5];
  logic [5:0] modes [7];

  assign sda_line = ~(sda_pull_low | (smb_sda_oe & ~smb_sda_out));
  assign pins = {2'h0, in_level, pd, pull_up, pull_down, in_buf_en, drive_on};

  scr_top #(.DEFAULT_BUS_ADDR(ADDR0)) scr_top_i (
    .clk(clk), .rst(rst), .ce(ce), .smb_scl_in(scl),
    .smb_sda_in(sda_line), .smb_select(1'b1), .smb_sda_out(smb_sda_out),
    .smb_sda_oe(smb_sda_oe), .host_ddr_clock(host_clk),
    .pin0_gpout_level(gpout), .pin0_pad_in(pad_in),
    .pin0_pad_out(pad_out), .pin0_output_drive_on(drive_on),
    .pin0_pull_up(pull_up), .pin0_pull_down(pull_down),
    .pin0_in_buf_en(in_buf_en), .pin0_in_level(in_level),
    .out_buffer_power_down(pd));

  scr_host_model scr_host_model_i (
    .clk(clk), .sda_line(sda_line), .link_run(link_run), .scl(scl),
    .sda_pull_low(sda_pull_low), .host_ddr_clock(host_clk));

  always #2 clk = ~clk;

  task automatic check(input string what, input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check_regs(input logic [6:0] a);
    logic [7:0] exp [3];
    exp = '{{a, 1'b0}, 8'h00, {PIN0_MODE_RESET, PIN0_PULL_RESET,
            PIN0_INBUF_RESET, PIN0_DRIVE_RESET}};
    for (int i = 0; i < 3; i++) begin
      scr_host_model_i.read_reg(a, 8'(i), d, ok);
      check("register", d, exp[i]);
      check("read ack", {7'h0, ok}, 8'h01);
    end
  endtask

  // A hang counts as a mismatch; about twice the planned run
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    gpout = 1'b1;
    pad_in = 1'b1;
    link_run = 1'b1;
    ce = 1'b1;
    fail_count = 0;
    total_checks = 0;
    // Every row keeps input buffer and driver exclusive
    rows = '{'{OFS_RESET_CTRL, 8'h10, 8'h10, 6'h15},
             '{OFS_RESET_CTRL, 8'hee, 8'h00, 6'h05},
             '{OFS_PIN0_CFG, 8'h0a, 8'h0a, 6'h2a},
             '{OFS_PIN0_CFG, 8'h3d, 8'h3d, 6'h01},
             '{8'h05, 8'hff, 8'h00, 6'h01}};
    // Link running, mode, expected pad level
    modes = '{6'h21, 6'h29, 6'h26, 6'h2c, 6'h24, 6'h07, 6'h08};
    tick(2);
    rst = 1'b0;
    tick(4);
    check_regs(ADDR0);
    foreach (rows[i]) begin
      scr_host_model_i.write_reg(ADDR0, rows[i].off, rows[i].wd, ok);
      scr_host_model_i.read_reg(ADDR0, rows[i].off, d, ok);
      check("readback", d, rows[i].rd);
      check("pins", pins, {2'h0, rows[i].pins});
    end
    foreach (modes[i]) begin
      link_run = modes[i][5];
      tick(300);
      scr_host_model_i.write_reg(ADDR0, OFS_PIN0_CFG,
                                 {modes[i][4:1], 4'h5}, ok);
      tick(2);
      check("pad", {7'h0, pad_out}, {7'h0, modes[i][0]});
    end
    link_run = 1'b1;
    // Bit 0 of the address byte is left zero
    scr_host_model_i.write_reg(ADDR0, OFS_BUS_ADDR, {ADDR1, 1'b0}, ok);
    scr_host_model_i.write_reg(ADDR0, OFS_RESET_CTRL, 8'h10, ok);
    check("stale addr ack", {7'h0, ok}, 8'h00);
    scr_host_model_i.write_reg(ADDR1, OFS_RESET_CTRL, 8'h10, ok);
    check("new addr ack", {7'h0, ok}, 8'h01);
    check("power down", pins, 8'h15);
    scr_host_model_i.write_reg(ADDR1, OFS_RESET_CTRL, 8'h11, ok);
    tick(4);
    check("pins after soft reset", pins, 8'h05);
    // A frozen device neither answers nor stores
    ce = 1'b0;
    scr_host_model_i.write_reg(ADDR1, OFS_PIN0_CFG, 8'h0a, ok);
    ce = 1'b1;
    check("frozen ack", {7'h0, ok}, 8'h00);
    check_regs(ADDR1);
    // A hard reset, unlike the soft one, restores the address
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(4);
    check("pins after reset", pins, 8'h05);
    check_regs(ADDR0);
    end_of_test();
  end
endmodule
